// ===== ppp_printer_port.sv
// pin-level parallel printer port: data latch, drivers, control lines, interrupt
//
// What this block does
// RQ1: printer data lines driven only while the external drive enable is low.
// RQ2: printer data lines float whenever the port is not selected.
// RQ3: printer pulls acknowledge low after taking a character.
// RQ4: printer raises media out when paper runs out.
// RQ5: printer holds busy high while it cannot accept data.
// RQ6: printer drives online high once selected.
// RQ7: printer pulls fault low on an error condition.
// RQ8: printer choose line driven low to select the printer.
// RQ9: initialize line driven low to start printer initialization.
// RQ10: autofeed line driven low to advance a line after each printed line.
// RQ11: data strobe pulsed low for at least 0.5 microseconds.
// RQ12: printer interrupt goes low when acknowledge goes low.
// RQ13: interrupt gated by its enable; floats while the enable is zero.
// RQ14: host drives the port select low to address this port.
// RQ15: bus buffer enable high whenever any channel is selected.
// RQ16: last host byte written while no strobe runs kept in a latch and presented on the data lines.
`default_nettype none
module ppp_printer_port
  import ppp_pkg::*;
#(
  parameter int PULSE_CYCLES = STROBE_CYCLES
) (
  input  wire logic              sys_clk_i,                // system clock
  input  wire logic              rst_i,                    // synchronous reset, high
  // host side
  input  wire logic              port_select_n_i,          // parallel port select, low
  input  wire logic              serial0_select_n_i,       // serial channel 0 select, low
  input  wire logic              serial1_select_n_i,       // serial channel 1 select, low
  input  wire logic              host_wr_i,                // write byte to data latch
  input  wire logic [7:0]        host_data_i,              // byte to print
  input  wire logic              strobe_req_i,             // request one data strobe
  input  wire logic              ctrl_choose_i,            // select the printer
  input  wire logic              ctrl_init_i,              // hold printer in init
  input  wire logic              ctrl_autofeed_i,          // auto line feed
  input  wire logic              ctrl_irq_en_i,            // interrupt pin enable
  output logic [STAT_W-1:0]      status_o,                 // sampled printer status
  output logic                   strobe_busy_o,            // strobe pulse in progress
  output logic                   bus_buffer_enable_o,      // system bus buffer enable
  // printer side
  input  wire logic              printer_drive_enable_n_i, // data driver enable, low
  input  wire logic              ack_n_i,                  // acknowledge, low
  input  wire logic              media_out_i,              // paper empty, high
  input  wire logic              busy_i,                   // printer busy, high
  input  wire logic              printer_online_i,         // printer selected, high
  input  wire logic              fault_n_i,                // printer error, low
  output logic [7:0]             printer_data_lines_o,     // data line levels
  output logic                   printer_data_lines_oe_o,  // data drivers on, high
  output logic                   data_latch_pulse_n_o,     // data strobe, low
  output logic                   printer_choose_n_o,       // printer select, low
  output logic                   init_n_o,                 // initialize, low
  output logic                   auto_line_feed_n_o,       // autofeed, low
  output logic                   printer_irq_o,            // interrupt level, low active
  output logic                   printer_irq_oe_o          // interrupt driver on, high
);

  logic [7:0]        data_d;
  logic              oe_d;
  logic              choose_n_d;
  logic              init_n_d;
  logic              afd_n_d;
  logic              irq_d;
  logic              irq_oe_d;
  logic              bbe_d;
  logic [STAT_W-1:0] stat_d;
  logic              strobe_start;

  // the strobe owns the timing; a new byte may not change under it
  assign strobe_start = strobe_req_i & ~strobe_busy_o; // RQ11

  ppp_strobe_gen #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) ppp_strobe_gen_i (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (strobe_start),
    .pulse_n_o (data_latch_pulse_n_o),
    .busy_o    (strobe_busy_o)
  );

  always_comb begin
    data_d = printer_data_lines_o;
    // writes during a strobe are dropped so the printer latches a stable byte
    if (host_wr_i && !port_select_n_i && !strobe_busy_o) begin // RQ14
      data_d = host_data_i; // RQ16
    end
    // drivers need both the external enable and the port select
    oe_d       = ~printer_drive_enable_n_i & ~port_select_n_i; // RQ1 RQ2
    choose_n_d = ~ctrl_choose_i;   // RQ8
    init_n_d   = ~ctrl_init_i;     // RQ9
    afd_n_d    = ~ctrl_autofeed_i; // RQ10
    // interrupt pin follows acknowledge; printer pulls it low per char
    irq_d      = ack_n_i;          // RQ12 RQ3
    irq_oe_d   = ctrl_irq_en_i;    // RQ13
    bbe_d      = ~port_select_n_i | ~serial0_select_n_i | ~serial1_select_n_i; // RQ15
    stat_d                 = '0;
    stat_d[STAT_ACK_N]     = ack_n_i;          // RQ3
    stat_d[STAT_BUSY]      = busy_i;           // RQ5
    stat_d[STAT_MEDIA_OUT] = media_out_i;      // RQ4
    stat_d[STAT_ONLINE]    = printer_online_i; // RQ6
    stat_d[STAT_FAULT_N]   = fault_n_i;        // RQ7
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      printer_data_lines_o    <= DATA_RST;
      printer_data_lines_oe_o <= 1'b0;
      printer_choose_n_o      <= LINE_N_RST;
      init_n_o                <= LINE_N_RST;
      auto_line_feed_n_o      <= LINE_N_RST;
      printer_irq_o           <= 1'b1;
      printer_irq_oe_o        <= 1'b0;
      bus_buffer_enable_o     <= 1'b0;
      status_o                <= STAT_RST;
    end else begin
      printer_data_lines_o    <= data_d;
      printer_data_lines_oe_o <= oe_d;
      printer_choose_n_o      <= choose_n_d;
      init_n_o                <= init_n_d;
      auto_line_feed_n_o      <= afd_n_d;
      printer_irq_o           <= irq_d;
      printer_irq_oe_o        <= irq_oe_d;
      bus_buffer_enable_o     <= bbe_d;
      status_o                <= stat_d;
    end
  end

  // helper: length of the current low strobe, read only by assertions
  logic [STROBE_CNT_W:0] a_low_cnt_q;
  logic [STROBE_CNT_W:0] a_low_cnt_d;

  always_comb begin
    a_low_cnt_d = '0;
    if (!data_latch_pulse_n_o) begin
      a_low_cnt_d = a_low_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      a_low_cnt_q <= '0;
    end else begin
      a_low_cnt_q <= a_low_cnt_d;
    end
  end

  a_data_float_off: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ1
    printer_drive_enable_n_i |=> !printer_data_lines_oe_o)
    else $error("data drivers on while external enable high");

  a_data_unselected: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ2
    port_select_n_i |=> !printer_data_lines_oe_o)
    else $error("data drivers on while port not selected");

  a_data_drive_on: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ1
    (!printer_drive_enable_n_i && !port_select_n_i) |=> printer_data_lines_oe_o)
    else $error("data drivers off while enabled and selected");

  a_latch_write: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ16
    (host_wr_i && !port_select_n_i && !strobe_busy_o)
      |=> printer_data_lines_o == $past(host_data_i))
    else $error("data latch missed a host write");

  a_latch_stable: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ16
    (strobe_busy_o || port_select_n_i || !host_wr_i) |=> $stable(printer_data_lines_o))
    else $error("data latch changed without a write");

  a_strobe_width: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ11
    $rose(data_latch_pulse_n_o) |-> a_low_cnt_q == (STROBE_CNT_W+1)'(PULSE_CYCLES))
    else $error("strobe low time wrong");

  a_strobe_start: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ11
    (strobe_req_i && !strobe_busy_o) |=> !data_latch_pulse_n_o ##1 !data_latch_pulse_n_o)
    else $error("strobe did not start on request");

  a_irq_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ12
    $fell(ack_n_i) |=> !printer_irq_o)
    else $error("interrupt did not fall with acknowledge");

  a_irq_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ13
    !ctrl_irq_en_i |=> !printer_irq_oe_o)
    else $error("interrupt driven while disabled");

  a_ctrl_lines: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ8 RQ9 RQ10
    ##1 (printer_choose_n_o == !$past(ctrl_choose_i)) && (init_n_o == !$past(ctrl_init_i))
      && (auto_line_feed_n_o == !$past(ctrl_autofeed_i)))
    else $error("control line does not follow its request");

  a_bus_buffer: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ15
    ##1 bus_buffer_enable_o == !($past(port_select_n_i) && $past(serial0_select_n_i)
      && $past(serial1_select_n_i)))
    else $error("bus buffer enable wrong");

  a_irq_release: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ12
    $rose(ack_n_i) |=> printer_irq_o)
    else $error("interrupt stayed low after acknowledge released");

  a_irq_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ13
    ctrl_irq_en_i |=> printer_irq_oe_o)
    else $error("interrupt not driven while enabled");

  a_status_levels: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ4 RQ5 RQ6
    ##1 (status_o[STAT_BUSY] == $past(busy_i))
      && (status_o[STAT_MEDIA_OUT] == $past(media_out_i))
      && (status_o[STAT_ONLINE] == $past(printer_online_i)))
    else $error("printer status level not sampled");

  // low-active status bits must pass through without inversion
  a_status_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ3 RQ7
    ##1 (status_o[STAT_ACK_N] == $past(ack_n_i))
      && (status_o[STAT_FAULT_N] == $past(fault_n_i)))
    else $error("printer low-active status not sampled");

  c_strobe_done: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(data_latch_pulse_n_o));
  c_irq_fire: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    printer_irq_oe_o && $fell(printer_irq_o));
  c_data_driven: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(printer_data_lines_oe_o));
  c_write_blocked: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    host_wr_i && !port_select_n_i && strobe_busy_o);
  c_ack_seen: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(status_o[STAT_ACK_N]));

endmodule
`default_nettype wire

// ===== ppp_pkg.sv
// shared constants of the printer parallel port
`default_nettype none
package ppp_pkg;
  // strobe timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int STROBE_MIN_NS  = 500;
  // least time rounds up to whole cycles
  localparam int STROBE_CYCLES  = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CNT_W   = 8;

  // printer status word field positions
  localparam int STAT_ACK_N     = 0;
  localparam int STAT_BUSY      = 1;
  localparam int STAT_MEDIA_OUT = 2;
  localparam int STAT_ONLINE    = 3;
  localparam int STAT_FAULT_N   = 4;
  localparam int STAT_W         = 5;

  // values after reset
  localparam logic [7:0]        DATA_RST   = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST   = 5'h11;
  localparam logic              LINE_N_RST = 1'b1;

  typedef enum logic [0:0] {
    PPP_ST_IDLE  = 1'b0,
    PPP_ST_PULSE = 1'b1
  } ppp_strobe_state_t;
endpackage
`default_nettype wire

// ===== ppp_strobe_gen.sv
// timed low pulse generator for the data latch strobe
`default_nettype none
module ppp_strobe_gen
  import ppp_pkg::*;
#(
  parameter int PULSE_CYCLES = STROBE_CYCLES
) (
  input  wire logic sys_clk_i,    // system clock
  input  wire logic rst_i,        // synchronous reset, high
  input  wire logic start_i,      // pulse request
  output logic      pulse_n_o,    // strobe, low while active
  output logic      busy_o        // high while the pulse runs
);

  generate
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > (2 ** STROBE_CNT_W)) begin : g_bad
      $error("ppp_strobe_gen: PULSE_CYCLES out of range");
    end
  endgenerate

  localparam logic [STROBE_CNT_W-1:0] LAST = STROBE_CNT_W'(PULSE_CYCLES - 1);

  ppp_strobe_state_t         state_q, state_d;
  logic [STROBE_CNT_W-1:0]   cnt_q, cnt_d;
  logic                      pulse_n_d;
  logic                      busy_d;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    pulse_n_d = pulse_n_o;
    busy_d    = busy_o;
    case (state_q)
      PPP_ST_IDLE: begin
        // a request that arrives mid pulse is ignored, not queued
        if (start_i) begin
          state_d   = PPP_ST_PULSE;
          cnt_d     = LAST;
          pulse_n_d = 1'b0;
          busy_d    = 1'b1;
        end
      end
      PPP_ST_PULSE: begin
        if (cnt_q == '0) begin
          state_d   = PPP_ST_IDLE;
          pulse_n_d = 1'b1;
          busy_d    = 1'b0;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d   = PPP_ST_IDLE;
        pulse_n_d = 1'b1;
        busy_d    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q   <= PPP_ST_IDLE;
      cnt_q     <= '0;
      pulse_n_o <= 1'b1;
      busy_o    <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      pulse_n_o <= pulse_n_d;
      busy_o    <= busy_d;
    end
  end

endmodule
`default_nettype wire

// ===== ppp_printer_model.sv
// behavioural line printer on the far side of the parallel port
`default_nettype none
module ppp_printer_model #(
  parameter int BUSY_CYCLES = 4,
  parameter int ACK_CYCLES  = 2
) (
  input  wire logic       sys_clk_i,   // system clock
  input  wire logic       rst_i,       // synchronous reset, high
  input  wire logic       strobe_n_i,  // data strobe from the port
  input  wire logic       choose_n_i,  // printer select from the port
  input  wire logic [7:0] data_i,      // data line levels from the port
  input  wire logic       data_oe_i,   // port drives the data lines
  input  wire logic       paper_out_i, // bench: printer has no paper
  input  wire logic       error_i,     // bench: printer has an error
  output logic            ack_n_o,     // acknowledge, low
  output logic            busy_o,      // busy, high
  output logic            media_out_o, // paper empty, high
  output logic            online_o,    // selected, high
  output logic            fault_n_o,   // error, low
  output logic [7:0]      got_o        // last byte latched
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       strobe_q;
  logic [7:0] seen;
  int         cnt_q;
  // a released bus must not look like the last byte
  assign seen = data_oe_i ? data_i : ~data_i;
  always_ff @(posedge sys_clk_i) begin
    strobe_q <= strobe_n_i;
    if (rst_i) begin
      cnt_q <= 0;
      got_o <= 8'h00;
    end else if (strobe_n_i && !strobe_q) begin
      got_o <= seen;
      cnt_q <= BUSY_CYCLES + ACK_CYCLES;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign busy_o      = (cnt_q > 0);
  assign ack_n_o     = !(cnt_q > 0 && cnt_q <= ACK_CYCLES);
  assign media_out_o = paper_out_i;
  assign online_o    = !choose_n_i;
  assign fault_n_o   = !error_i;
endmodule
`default_nettype wire

// ===== ppp_printer_port_test.sv
// self-checking bench of the parallel printer port
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ppp_printer_port_test
  import ppp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE = 3;
  logic sys_clk, rst, sel_n, s0_n, s1_n, wr, req, choose, init, afd, irq_en, en_n;
  logic paper, perr, ack_n, busy, mout, online, fault_n;
  logic [7:0] hd, lines, got;
  logic [STAT_W-1:0] stat;
  logic sbusy, bbe, oe, stb_n, choose_n, init_n, afd_n, irq, irq_oe;
  int err_count, comparisons;
  ppp_printer_port #(.PULSE_CYCLES(PULSE)) ppp_printer_port_i (.sys_clk_i(sys_clk), .rst_i(rst),
    .port_select_n_i(sel_n), .serial0_select_n_i(s0_n), .serial1_select_n_i(s1_n),
    .host_wr_i(wr), .host_data_i(hd), .strobe_req_i(req), .ctrl_choose_i(choose),
    .ctrl_init_i(init), .ctrl_autofeed_i(afd), .ctrl_irq_en_i(irq_en), .status_o(stat),
    .strobe_busy_o(sbusy), .bus_buffer_enable_o(bbe), .printer_drive_enable_n_i(en_n),
    .ack_n_i(ack_n), .media_out_i(mout), .busy_i(busy), .printer_online_i(online),
    .fault_n_i(fault_n), .printer_data_lines_o(lines), .printer_data_lines_oe_o(oe),
    .data_latch_pulse_n_o(stb_n), .printer_choose_n_o(choose_n), .init_n_o(init_n),
    .auto_line_feed_n_o(afd_n), .printer_irq_o(irq), .printer_irq_oe_o(irq_oe));
  ppp_printer_model ppp_printer_model_i (.sys_clk_i(sys_clk), .rst_i(rst), .strobe_n_i(stb_n),
    .choose_n_i(choose_n), .data_i(lines), .data_oe_i(oe), .paper_out_i(paper),
    .error_i(perr), .ack_n_o(ack_n), .busy_o(busy), .media_out_o(mout),
    .online_o(online), .fault_n_o(fault_n), .got_o(got));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_drivers();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      sel_n <= i[0];
      en_n  <= i[1];
      settle(1);
      `CHK(oe, !i[0] && !i[1])
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {s1_n, s0_n, sel_n} <= ~(3'h1 << i);
      settle(1);
      `CHK(bbe, i < 3)
    end
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      {afd, init, choose} <= i[2:0];
      settle(2);
      `CHK({afd_n, init_n, choose_n}, ~i[2:0])
      `CHK(stat[STAT_ONLINE], i[0])
    end
  endtask
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {perr, paper} <= i[1:0];
      settle(2);
      `CHK({stat[STAT_FAULT_N], stat[STAT_MEDIA_OUT]}, {!i[1], i[0]})
    end
  endtask
  task automatic t_irq_gate();
    @(posedge sys_clk);
    irq_en <= 1'b0;
    settle(1);
    `CHK(irq_oe, 1'b0)
    @(posedge sys_clk);
    irq_en <= 1'b1;
    settle(1);
    `CHK(irq_oe, 1'b1)
  endtask
  // write, strobe, and a write inside the pulse that must be dropped
  task automatic t_print(input logic [7:0] b);
    int n;
    @(posedge sys_clk);
    {sel_n, en_n, wr, hd} <= {1'b0, 1'b0, 1'b1, b};
    @(posedge sys_clk);
    {wr, req} <= 2'b01;
    @(posedge sys_clk);
    {wr, req, hd} <= {1'b1, 1'b0, ~b};
    #1;
    `CHK(lines, b)
    `CHK(sbusy, 1'b1)
    n = 0;
    while (stb_n === 1'b0 && n < 50) begin
      n++;
      @(posedge sys_clk);
      wr <= 1'b0;
      #1;
    end
    `CHK(n, PULSE)
    `CHK(sbusy, 1'b0)
    `CHK(lines, b)
    n = 0;
    while (ack_n !== 1'b0 && n < 50) begin
      settle(1);
      n++;
    end
    settle(1);
    `CHK(irq, 1'b0)
    `CHK(stat[STAT_ACK_N], 1'b0)
    `CHK(stat[STAT_BUSY], 1'b1)
    `CHK(got, b)
    settle(6);
    `CHK(irq, 1'b1)
  endtask
  initial begin
    {rst, sel_n, s0_n, s1_n, en_n} = 5'h1F;
    {wr, req, choose, init, afd, irq_en, paper, perr} = 8'h00;
    hd = 8'h00;
    err_count = 0;
    comparisons = 0;
    settle(4);
    `CHK({lines, oe, stb_n, choose_n, init_n, afd_n}, {8'h00, 5'h0F})
    `CHK({irq, irq_oe, bbe, sbusy, stat}, {4'h8, STAT_RST})
    @(posedge sys_clk);
    rst <= 1'b0;
    t_drivers();
    t_ctrl();
    t_status();
    t_irq_gate();
    t_print(8'hA5);
    t_print(8'h3C);
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
